// >>> pkg/fpws_pkg.sv
/*
  Shared constants for the flash page write sequencer.
  Assumes a single core clock domain; one machine cycle per clock.
*/
package fpws_pkg;
  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int unsigned FCTL_KEY_MSB   = 7;
  localparam int unsigned FCTL_KEY_LSB   = 4;
  localparam int unsigned FCTL_PS_BIT    = 3;
  localparam int unsigned FCTL_SEL1_BIT  = 2;
  localparam int unsigned FCTL_SEL0_BIT  = 1;
  localparam logic [3:0]  KEY_UNLOCK     = 4'h5;
  localparam logic [3:0]  KEY_LAUNCH     = 4'ha;
  localparam logic [7:0]  FCTL_RESET     = 8'h00;
  // ----------------------------------------
  // Space select encodings
  // ----------------------------------------
  localparam logic [1:0]  SEL_USER       = 2'h0;
  localparam logic [1:0]  SEL_EXTRA      = 2'h1;
  localparam logic [1:0]  SEL_FUSE       = 2'h2;
  localparam logic [1:0]  SEL_CLR_LATCH  = 2'h3;
  // ----------------------------------------
  // Page geometry, boot window, timing
  // ----------------------------------------
  localparam int unsigned PAGE_BYTES     = 128;
  localparam int unsigned COL_W          = 7;
  localparam logic [15:0] BOOT_BASE      = 16'hf800;
  localparam int unsigned LAUNCH_DELAY   = 2;
  localparam int unsigned PROG_CYCLES    = 64;
  localparam int unsigned ERASE_CYCLES   = 32;
endpackage

// >>> hdl/fpws_col_latch.sv
/*
  Column latch array: 128 bytes of data each with a loaded marker.
  Assumes writes already gated by the sequencer; clear has priority.
*/
`timescale 1ns/1ps
module fpws_col_latch
#(
  parameter int unsigned DEPTH = fpws_pkg::PAGE_BYTES,
  parameter int unsigned AW    = fpws_pkg::COL_W
)
(
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_col,
  input  wire logic [7:0]       wr_data,
  input  wire logic             clr_all,
  input  wire logic [AW-1:0]    rd_col,
  output logic      [7:0]       rd_data,
  output logic                  rd_loaded,
  output logic                  any_loaded
);
  import fpws_pkg::*;

  logic [7:0]       data_q [DEPTH];
  logic [DEPTH-1:0] loaded_q;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : gen_col
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          data_q[g]   <= 8'hff;
          loaded_q[g] <= 1'b0;
        end
        else if (clr_all)
        begin
          data_q[g]   <= 8'hff;
          loaded_q[g] <= 1'b0;
        end
        else if (wr_en && (wr_col == AW'(g)))
        begin
          data_q[g]   <= wr_data;
          loaded_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  assign rd_data    = data_q[rd_col];
  assign rd_loaded  = loaded_q[rd_col];
  assign any_loaded = |loaded_q;
endmodule

// >>> hdl/fpws_seq.sv
/*
  Flash page write sequencer: unlock/launch decode, busy timing, per-byte
  erase then program of loaded column latches.
  Assumes core writes arrive as one-cycle strobes in the core clock domain,
  one machine cycle per clock; the flash array sits outside.
*/
`timescale 1ns/1ps
module fpws_seq
#(
  parameter int unsigned ERASE_CNT = fpws_pkg::ERASE_CYCLES,
  parameter int unsigned PROG_CNT  = fpws_pkg::PROG_CYCLES
)
(
  input  wire logic          core_clk,
  input  wire logic          resetn,
  input  wire logic          ctrl_wr,
  input  wire logic [7:0]    ctrl_wdata,
  output logic      [7:0]    flash_control_reg,
  input  wire logic          status_clr_err,
  output logic               sequence_error_bit,
  output logic               latches_loaded,
  input  wire logic          xdata_wr,
  input  wire logic [15:0]   xdata_addr,
  input  wire logic [7:0]    xdata_wdata,
  input  wire logic          boot_map_enable,
  input  wire logic [15:0]   code_addr,
  output logic               boot_flash_space,
  output logic               flash_erase,
  output logic               flash_prog,
  output logic [1:0]         flash_space,
  output logic [15:0]        flash_addr,
  output logic [7:0]         flash_wdata
);
  import fpws_pkg::*;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_ARM   = 3'b001,
    ST_SCAN  = 3'b010,
    ST_ERASE = 3'b011,
    ST_PROG  = 3'b100
  } fpws_state_e;

  fpws_state_e  state_q;
  logic [7:0]   ctl_q;
  logic         unlocked_q;
  logic [1:0]   unl_sel_q;
  logic         err_q;
  logic [8:0]   page_q;
  logic [COL_W-1:0] col_q;
  logic [15:0]  tmr_q;
  logic [1:0]   run_sel_q;
  logic         busy;
  logic         launch_ok;
  logic         launch_bad;
  logic         latch_wr;
  logic         clr_latch;
  logic [7:0]   rd_data;
  logic         rd_loaded;
  logic         any_loaded;
  logic         done;

  function automatic logic [1:0] sel_of(input logic [7:0] v);
    sel_of = {v[FCTL_SEL1_BIT], v[FCTL_SEL0_BIT]};
  endfunction

  // ----------------------------------------
  // Launch decode
  // ----------------------------------------
  wire logic [3:0] key = ctrl_wdata[FCTL_KEY_MSB:FCTL_KEY_LSB];
  assign busy      = (state_q != ST_IDLE);
  assign launch_ok = ctrl_wr && unlocked_q && (key == KEY_LAUNCH)
                     && (sel_of(ctrl_wdata) == unl_sel_q) && !busy;
  assign launch_bad = ctrl_wr && !busy &&
                      ((unlocked_q && !launch_ok) || (!unlocked_q && key == KEY_LAUNCH));
  assign latch_wr  = xdata_wr && ctl_q[FCTL_PS_BIT] && !busy;
  assign done      = (state_q == ST_PROG) && (tmr_q == 16'h0000) && (col_q == COL_W'(PAGE_BYTES - 1));

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      unlocked_q <= 1'b0;
      unl_sel_q  <= SEL_USER;
    end
    else
    begin
      // Unlock lasts one cycle: any cycle without an unlock-key write drops it
      unlocked_q <= ctrl_wr && (key == KEY_UNLOCK) && !busy;
      if (ctrl_wr)
        unl_sel_q <= sel_of(ctrl_wdata);
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ctl_q <= FCTL_RESET;
    else if (ctrl_wr && !busy)
      ctl_q <= ctrl_wdata;
  end

  // Busy read back in bit 0; key nibble reads as zero
  assign flash_control_reg = {4'h0, ctl_q[FCTL_PS_BIT], ctl_q[FCTL_SEL1_BIT], ctl_q[FCTL_SEL0_BIT], busy};

  // ----------------------------------------
  // Sequence error flag
  // ----------------------------------------
  wire logic last_scan = (state_q == ST_SCAN) && !rd_loaded && (col_q == COL_W'(PAGE_BYTES - 1));
  wire logic empty_launch = launch_ok && (sel_of(ctrl_wdata) != SEL_CLR_LATCH) && !any_loaded;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      err_q <= 1'b0;
    else if (launch_bad || empty_launch)
      err_q <= 1'b1;
    else if (status_clr_err || done || last_scan)
      err_q <= 1'b0;
  end
  assign sequence_error_bit = err_q;
  assign latches_loaded     = any_loaded;

  // ----------------------------------------
  // Page address from last loaded latch
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      page_q <= 9'h000;
    else if (latch_wr)
      page_q <= xdata_addr[15:COL_W];
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q   <= ST_IDLE;
      col_q     <= '0;
      tmr_q     <= 16'h0000;
      run_sel_q <= SEL_USER;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (launch_ok && sel_of(ctrl_wdata) != SEL_CLR_LATCH && any_loaded)
          begin
            state_q   <= ST_ARM;
            run_sel_q <= sel_of(ctrl_wdata);
            col_q     <= '0;
          end
        end
        ST_ARM:
          state_q <= ST_SCAN;
        ST_SCAN:
        begin
          if (rd_loaded)
          begin
            state_q <= ST_ERASE;
            tmr_q   <= 16'(ERASE_CNT - 1);
          end
          else if (col_q == COL_W'(PAGE_BYTES - 1))
            state_q <= ST_IDLE;
          else
            col_q <= col_q + COL_W'(1);
        end
        ST_ERASE:
        begin
          if (tmr_q == 16'h0000)
          begin
            state_q <= ST_PROG;
            tmr_q   <= 16'(PROG_CNT - 1);
          end
          else
            tmr_q <= tmr_q - 16'h0001;
        end
        ST_PROG:
        begin
          if (tmr_q != 16'h0000)
            tmr_q <= tmr_q - 16'h0001;
          else if (col_q == COL_W'(PAGE_BYTES - 1))
            state_q <= ST_IDLE;
          else
          begin
            state_q <= ST_SCAN;
            col_q   <= col_q + COL_W'(1);
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Latches clear after a completed write or on the latch reset command
  assign clr_latch = done || last_scan ||
                     (launch_ok && sel_of(ctrl_wdata) == SEL_CLR_LATCH);

  fpws_col_latch u_latch
  (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .wr_en      (latch_wr),
    .wr_col     (xdata_addr[COL_W-1:0]),
    .wr_data    (xdata_wdata),
    .clr_all    (clr_latch),
    .rd_col     (col_q),
    .rd_data    (rd_data),
    .rd_loaded  (rd_loaded),
    .any_loaded (any_loaded)
  );

  // ----------------------------------------
  // Flash array strobes
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flash_erase <= 1'b0;
      flash_prog  <= 1'b0;
      flash_space <= SEL_USER;
      flash_addr  <= 16'h0000;
      flash_wdata <= 8'hff;
    end
    else
    begin
      flash_erase <= (state_q == ST_ERASE);
      flash_prog  <= (state_q == ST_PROG);
      flash_space <= run_sel_q;
      flash_addr  <= {page_q, col_q};
      flash_wdata <= rd_data;
    end
  end

  assign boot_flash_space = boot_map_enable && (code_addr >= BOOT_BASE);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_launch;
    launch_ok && sel_of(ctrl_wdata) != SEL_CLR_LATCH && any_loaded;
  endsequence

  chk_busy_start: assert property (@(posedge core_clk) disable iff (!resetn)
    s_launch |=> state_q == ST_ARM ##1 state_q == ST_SCAN)
    else $error("Programming did not start on second cycle");
  chk_busy_flag: assert property (@(posedge core_clk) disable iff (!resetn)
    s_launch |=> flash_control_reg[0] [*2])
    else $error("Busy flag not set after launch");
  chk_no_consec: assert property (@(posedge core_clk) disable iff (!resetn)
    (ctrl_wr && key == KEY_LAUNCH && !$past(ctrl_wr)) |=> !busy || $past(busy))
    else $error("Launch accepted without unlock");
  chk_sel_match: assert property (@(posedge core_clk) disable iff (!resetn)
    (ctrl_wr && unlocked_q && sel_of(ctrl_wdata) != unl_sel_q && !busy) |=> !busy)
    else $error("Launch accepted with mismatched select");
  chk_empty_error: assert property (@(posedge core_clk) disable iff (!resetn)
    empty_launch |=> sequence_error_bit && !busy)
    else $error("Empty launch did not flag error");
  chk_latch_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (busy && xdata_wr) |=> $stable(page_q))
    else $error("Latch page changed while busy");
  chk_ps_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    (xdata_wr && !ctl_q[FCTL_PS_BIT] && !busy && !clr_latch) |=> $stable(any_loaded))
    else $error("Latch written without page select");
  chk_done_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    done |=> !busy && !any_loaded && !sequence_error_bit)
    else $error("Completion did not clear busy, latches or error");
  chk_unloaded: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_q == ST_SCAN && !rd_loaded) |=> state_q != ST_ERASE)
    else $error("Unloaded byte entered erase");
endmodule

// >>> verif/fpws_core_model.sv
/*
  Core model: control writes, latch stores and error clears as strobes.
  Assumes driving at the falling edge of core_clk, sampling at the rising one.
*/
`timescale 1ns/1ps
module fpws_core_model
(
  input  wire logic        core_clk,
  output logic             ctrl_wr,
  output logic [7:0]       ctrl_wdata,
  output logic             status_clr_err,
  output logic             xdata_wr,
  output logic [15:0]      xdata_addr,
  output logic [7:0]       xdata_wdata
);
  import fpws_pkg::*;
  initial
  begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 8'h00;
    status_clr_err = 1'b0;
    xdata_wr = 1'b0;
    xdata_addr = 16'h0000;
    xdata_wdata = 8'h00;
  end
  // Released lines show the inverse, so stale data never passes as valid
  task automatic wr_ctrl(input logic [7:0] d);
    @(negedge core_clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = d;
    @(negedge core_clk);
    ctrl_wr = 1'b0;
    ctrl_wdata = ~d;
  endtask
  task automatic launch(input logic [1:0] s1, input logic [1:0] s2);
    @(negedge core_clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = {KEY_UNLOCK, 1'b1, s1, 1'b0};
    @(negedge core_clk);
    ctrl_wdata = {KEY_LAUNCH, 1'b1, s2, 1'b0};
    @(negedge core_clk);
    ctrl_wr = 1'b0;
    ctrl_wdata = ~ctrl_wdata;
  endtask
  // Only the 16-bit pointer store is modelled
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    xdata_wr = 1'b1;
    xdata_addr = a;
    xdata_wdata = d;
    @(negedge core_clk);
    xdata_wr = 1'b0;
    xdata_addr = ~a;
    xdata_wdata = ~d;
  endtask
  task automatic clr_err;
    @(negedge core_clk);
    status_clr_err = 1'b1;
    @(negedge core_clk);
    status_clr_err = 1'b0;
  endtask
endmodule

// >>> verif/flash_page_write_sequencer_tb_top.sv
/*
  Testbench for the sequencer with short erase and program counts.
  Assumes the core model drives the control, error-clear and store inputs; boot_map_enable and code_addr are driven here.
*/
`timescale 1ns/1ps
module flash_page_write_sequencer_tb_top;
  import fpws_pkg::*;
  localparam int unsigned EC = 2;
  localparam int unsigned PC = 2;
  logic        core_clk, resetn, ctrl_wr, status_clr_err, xdata_wr, boot_map_enable;
  logic        sequence_error_bit, latches_loaded, boot_flash_space, flash_erase, flash_prog;
  logic [7:0]  ctrl_wdata, flash_control_reg, xdata_wdata, flash_wdata;
  logic [15:0] xdata_addr, code_addr, flash_addr;
  logic [1:0]  flash_space, last_space;
  logic        bad_order;
  int          error_cnt, cmp_count, erase_cyc, prog_cyc;
  logic [7:0]  prog_mem [logic [15:0]];

  fpws_seq #(.ERASE_CNT(EC), .PROG_CNT(PC)) uut
  (
    .core_clk(core_clk), .resetn(resetn), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .flash_control_reg(flash_control_reg), .status_clr_err(status_clr_err),
    .sequence_error_bit(sequence_error_bit), .latches_loaded(latches_loaded),
    .xdata_wr(xdata_wr), .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
    .boot_map_enable(boot_map_enable), .code_addr(code_addr), .boot_flash_space(boot_flash_space),
    .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_space(flash_space),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata)
  );
  fpws_core_model core
  (
    .core_clk(core_clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .status_clr_err(status_clr_err),
    .xdata_wr(xdata_wr), .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Flash array side: records what reaches each location
  always @(posedge core_clk)
  begin
    if (flash_erase)
      erase_cyc++;
    if (flash_prog)
    begin
      if (erase_cyc == 0)
        bad_order = 1'b1;
      prog_cyc++;
      prog_mem[flash_addr] = flash_wdata;
      last_space = flash_space;
    end
  end

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk8(flash_control_reg, FCTL_RESET);
    chk1(sequence_error_bit, 1'b0);
    chk1(latches_loaded, 1'b0);
  endtask
  task automatic t_errors;
    core.store(16'h0105, 8'h33);
    chk1(latches_loaded, 1'b0);
    core.launch(SEL_USER, SEL_USER);
    repeat (3) @(negedge core_clk);
    chk1(flash_control_reg[0], 1'b0);
    chk1(sequence_error_bit, 1'b1);
    core.clr_err;
    chk1(sequence_error_bit, 1'b0);
    core.wr_ctrl(8'h08);
    core.store(16'h0105, 8'h33);
    core.wr_ctrl(8'h00);
    core.launch(SEL_CLR_LATCH, SEL_CLR_LATCH);
    @(negedge core_clk);
    chk1(latches_loaded, 1'b0);
    chk1(sequence_error_bit, 1'b0);
    core.wr_ctrl(8'h08);
    core.store(16'h0105, 8'h33);
    core.wr_ctrl(8'h50);
    core.wr_ctrl(8'ha0);
    @(negedge core_clk);
    chk1(flash_control_reg[0], 1'b0);
    chk1(sequence_error_bit, 1'b1);
    core.launch(SEL_USER, SEL_EXTRA);
    @(negedge core_clk);
    chk1(flash_control_reg[0], 1'b0);
    core.launch(SEL_CLR_LATCH, SEL_CLR_LATCH);
  endtask
  // Loads n bytes in scrambled column order; the last store moves the page
  task automatic t_prog(input logic [1:0] sel, input int n);
    logic [6:0] col;
    int k;
    prog_mem.delete();
    erase_cyc = 0;
    prog_cyc = 0;
    bad_order = 1'b0;
    core.wr_ctrl({4'h0, 1'b1, sel, 1'b0});
    for (int i = 0; i < n; i++)
    begin
      col = 7'((i * 37) % 128);
      core.store({(i == n - 1) ? 9'h1a5 : 9'h003, col}, {1'b0, col} ^ 8'h5a);
    end
    core.wr_ctrl({KEY_LAUNCH, 4'h0});
    chk1(sequence_error_bit, 1'b1);
    chk1(latches_loaded, 1'b1);
    core.launch(sel, sel);
    @(negedge core_clk);
    chk1(flash_control_reg[0], 1'b1);
    core.store({9'h0c3, 7'h00}, 8'h11);
    for (k = 0; k < 3000 && flash_control_reg[0] !== 1'b0; k++)
      @(negedge core_clk);
    chk1(flash_control_reg[0], 1'b0);
    @(negedge core_clk);
    chk32(erase_cyc, n * EC);
    chk32(prog_cyc, n * PC);
    chk1(bad_order, 1'b0);
    chk32(prog_mem.num(), n);
    for (int i = 0; i < n; i++)
    begin
      col = 7'((i * 37) % 128);
      chk8(prog_mem[{9'h1a5, col}], {1'b0, col} ^ 8'h5a);
    end
    chk8({6'h00, last_space}, {6'h00, sel});
    chk1(latches_loaded, 1'b0);
    chk1(sequence_error_bit, 1'b0);
  endtask
  task automatic t_boot;
    logic [16:0] tbl [4] = '{{1'b1, 16'hf800}, {1'b1, 16'hf7ff}, {1'b1, 16'hffff}, {1'b0, 16'hf800}};
    logic exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      @(negedge core_clk);
      boot_map_enable = tbl[i][16];
      code_addr = tbl[i][15:0];
      #1 chk1(boot_flash_space, exp[i]);
    end
  endtask

  initial
  begin
    resetn = 1'b0;
    boot_map_enable = 1'b0;
    code_addr = 16'h0000;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    t_reset;
    t_errors;
    t_prog(SEL_USER, 128);
    t_prog(SEL_EXTRA, 1);
    t_prog(SEL_FUSE, 5);
    t_boot;
    test_done;
  end
  // Whole run is about 1300 cycles; the limit leaves wide margin
  initial
  begin
    #60us;
    error_cnt++;
    test_done;
  end
endmodule
